// ### bts_bit_test_skip.v
// Purpose: Decode and execute of the skip-if-bit-clear and skip-if-bit-set instructions.
// Assumes: File register data returns combinationally in the cycle the read address stands.
// Notes: Only one instruction in flight; ready is low until it has finished.
//        A registered decode edge takes the word before the execute cycle, so
//        the read address leaves a flip-flop; cycle counts start at execute.
//        ce_i low holds every register, the status outputs included.
//        Words with other opcodes are left alone and never make ready drop.
`timescale 1ns/1ns
`default_nettype none
`include "bts_defines.vh"

module bts_bit_test_skip
(
   // Clock, reset and enable
   input wire sys_clk_i,
   input wire srst_i,
   input wire ce_i,
   // Instruction handshake
   input wire instr_valid_i,
   input wire [15:0] instr_word_i,
   output wire instr_ready_o,
   // Operand context from the core
   input wire next_two_word_i,
   input wire ext_instr_en_i,
   input wire [`BTS_BANK_W-1:0] bank_select_register_i,
   input wire [`BTS_ADDR_W-1:0] index_base_i,
   // File register read port
   output reg [`BTS_ADDR_W-1:0] rd_addr_o,
   output reg rd_en_o,
   output reg indexed_o,
   input wire [7:0] rd_data_i,
   // Status towards the fetch unit
   output reg skip_o,
   output reg discard_o,
   output reg no_operation_o,
   output reg done_o
);

   // Execute, then zero, one or two no-operation cycles; the decode edge
   // that takes the word is not an instruction cycle of its own
   // One-hot states
   localparam [3:0] ST_IDLE = 4'h1; // Waiting for an instruction
   localparam [3:0] ST_EXEC = 4'h2; // Read and test cycle
   localparam [3:0] ST_NOP1 = 4'h4; // First no-operation cycle
   localparam [3:0] ST_NOP2 = 4'h8; // Second no-operation over a two-word instruction

   reg [3:0] state; // Current state
   reg [3:0] next_state; // Next state
   reg [2:0] bit_idx; // Latched bit index
   reg skip_on_set; // High for the set variant
   reg two_word; // Prefetched instruction is two words
   wire [`BTS_ADDR_W-1:0] res_addr; // Resolved operand address
   wire res_indexed; // Resolved in indexed mode
   wire is_ours; // Word is one of the two instructions
   wire tested_bit; // Bit under test
   wire skip_now; // Skip condition in the execute cycle
   wire take; // Instruction accepted
   reg next_skip; // Skip decided at this edge
   reg next_nop; // Next cycle is a no-operation cycle
   reg next_done; // Instruction ends at this edge

   // Opcode field of the clear variant
   function is_clear_opc;
      input [15:0] word;
      begin
         is_clear_opc = (word[`BTS_OPC_HI:`BTS_OPC_LO] == `BTS_OPC_SKIP_CLEAR);
      end
   endfunction

   // Opcode field of the set variant, used by the match and by the test sense
   function is_set_opc;
      input [15:0] word;
      begin
         is_set_opc = (word[`BTS_OPC_HI:`BTS_OPC_LO] == `BTS_OPC_SKIP_SET);
      end
   endfunction

   // Recognises the two opcodes from one word
   function match_opc;
      input [15:0] word;
      begin
         match_opc = is_clear_opc(word) || is_set_opc(word);
      end
   endfunction

   assign is_ours = match_opc(instr_word_i);
   // Ready only while idle, so nothing is taken while busy
   assign instr_ready_o = (state == ST_IDLE);
   // Accepted only when enabled, valid, ready and recognised
   assign take = ce_i && instr_valid_i && instr_ready_o && is_ours;

   // Operand address from the incoming word
   // Resolved at decode so the read address can be registered
   bts_addr_resolve u_resolve
   (
      .file_addr_i(instr_word_i[`BTS_FILE_HI:`BTS_FILE_LO]),
      .access_flag_i(instr_word_i[`BTS_ACC_POS]),
      .ext_instr_en_i(ext_instr_en_i),
      .bank_select_register_i(bank_select_register_i),
      .index_base_i(index_base_i),
      .addr_o(res_addr),
      .indexed_o(res_indexed)
   );

   // Bit test on the returned file register data
   // The bit index was latched at decode; the data arrive combinationally
   assign tested_bit = rd_data_i[bit_idx];
   assign skip_now = skip_on_set ? tested_bit : ~tested_bit;

   // Next state selection
   always @*
   begin
      case (state)
         ST_IDLE:
         begin
            // Leave idle only on an accepted word
            next_state = take ? ST_EXEC : ST_IDLE;
         end
         ST_EXEC:
         begin
            // Skip adds a no-operation cycle, otherwise done in one
            next_state = skip_now ? ST_NOP1 : ST_IDLE;
         end
         ST_NOP1:
         begin
            // A two-word instruction needs a second discarded cycle
            next_state = two_word ? ST_NOP2 : ST_IDLE;
         end
         ST_NOP2:
         begin
            // Second discarded cycle always ends the instruction
            next_state = ST_IDLE;
         end
         default:
         begin
            // An illegal code recovers to idle
            next_state = ST_IDLE;
         end
      endcase
   end

   // State register and latched operands
   always @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         // Back to idle with nothing latched
         state <= ST_IDLE;
         bit_idx <= 3'h0;
         skip_on_set <= 1'b0;
         two_word <= 1'b0;
         rd_addr_o <= {`BTS_ADDR_W{1'b0}};
         rd_en_o <= 1'b0;
         indexed_o <= 1'b0;
      end
      else if (ce_i)
      begin
         // Registers move only while enabled
         state <= next_state;
         rd_en_o <= take;
         if (take)
         begin
            // Fields of the accepted word
            bit_idx <= instr_word_i[`BTS_BIT_HI:`BTS_BIT_LO];
            skip_on_set <= is_set_opc(instr_word_i);
            rd_addr_o <= res_addr;
            indexed_o <= res_indexed;
         end
         if (state == ST_EXEC)
         begin
            // Length of the prefetched instruction is known by now
            two_word <= next_two_word_i;
         end
      end
   end

   // Next values of the status outputs
   always @*
   begin
      // Skip decision at the end of the execute cycle
      next_skip = (state == ST_EXEC) && skip_now;
      // No-operation level for each discarded cycle
      next_nop = (next_state == ST_NOP1) || (next_state == ST_NOP2);
      // Done when a busy state returns to idle
      next_done = (state != ST_IDLE) && (next_state == ST_IDLE);
   end

   // Status outputs, each from a flip-flop
   always @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         // All status low after reset
         skip_o <= 1'b0;
         discard_o <= 1'b0;
         no_operation_o <= 1'b0;
         done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         // Pulse when the skip decision is taken
         skip_o <= next_skip;
         // Prefetched word dropped in the first no-operation cycle
         discard_o <= next_skip;
         // Level for each no-operation cycle
         no_operation_o <= next_nop;
         // Pulse after the last cycle of the instruction
         done_o <= next_done;
      end
   end

endmodule // bts_bit_test_skip
`default_nettype wire

// ### bts_defines.vh
// Purpose: Constants for the bit-test-and-skip decode and execute block.
// Assumes: Included by its bare name by every design file of the block.
// Notes: Definitions only, no logic.
`ifndef BTS_DEFINES_VH
`define BTS_DEFINES_VH

// Instruction word fields
`define BTS_OPC_HI 15
`define BTS_OPC_LO 12
`define BTS_BIT_HI 11
`define BTS_BIT_LO 9
`define BTS_ACC_POS 8
`define BTS_FILE_HI 7
`define BTS_FILE_LO 0

// Opcodes of the two instructions
`define BTS_OPC_SKIP_CLEAR 4'hb
`define BTS_OPC_SKIP_SET 4'ha

// Access bank split and indexed literal offset limit
`define BTS_ACC_LOW_LAST 8'h5f
`define BTS_ACC_HIGH_BANK 4'hf
`define BTS_ACC_LOW_BANK 4'h0

// Widths
`define BTS_ADDR_W 12
`define BTS_BANK_W 4

`endif

// ### bts_addr_resolve.v
// Purpose: Resolves the data memory address of a file register operand.
// Assumes: Purely combinational; inputs stable while the operand is used.
// Notes: Picks indexed, access bank or bank select register addressing.
`timescale 1ns/1ns
`default_nettype none
`include "bts_defines.vh"

module bts_addr_resolve
(
   input wire [7:0] file_addr_i,
   input wire access_flag_i,
   input wire ext_instr_en_i,
   input wire [`BTS_BANK_W-1:0] bank_select_register_i,
   input wire [`BTS_ADDR_W-1:0] index_base_i,
   output reg [`BTS_ADDR_W-1:0] addr_o,
   output reg indexed_o
);

   // Address selection by access flag, extension enable and offset range
   always @*
   begin
      indexed_o = 1'b0;
      if (access_flag_i)
      begin
         // Bank select register picks the general purpose register bank
         addr_o = {bank_select_register_i, file_addr_i};
      end
      else if (ext_instr_en_i && (file_addr_i <= `BTS_ACC_LOW_LAST))
      begin
         // Indexed literal offset from the index base
         addr_o = index_base_i + {4'h0, file_addr_i};
         indexed_o = 1'b1;
      end
      else if (file_addr_i <= `BTS_ACC_LOW_LAST)
      begin
         // Lower part of the access bank
         addr_o = {`BTS_ACC_LOW_BANK, file_addr_i};
      end
      else
      begin
         // Upper part of the access bank, the special function registers
         addr_o = {`BTS_ACC_HIGH_BANK, file_addr_i};
      end
   end

endmodule // bts_addr_resolve
`default_nettype wire

// ### bts_mon_monitor.sv
// Purpose: Port assertions for the bit test skip block.
// Assumes: Every check pauses while ce_i is low or srst_i is high.
// Notes: Bound to bts_bit_test_skip.
`timescale 1ns/1ns
`default_nettype none
module bts_mon
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_word_i,
   input wire logic instr_ready_o,
   input wire logic next_two_word_i,
   input wire logic ext_instr_en_i,
   input wire logic [3:0] bank_select_register_i,
   input wire logic [11:0] index_base_i,
   input wire logic [11:0] rd_addr_o,
   input wire logic rd_en_o,
   input wire logic indexed_o,
   input wire logic [7:0] rd_data_i,
   input wire logic skip_o,
   input wire logic discard_o,
   input wire logic no_operation_o,
   input wire logic done_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i || !ce_i);
   logic [15:0] w; // Word taken
   // Opcode a or b taken while idle
   wire take = ce_i && instr_valid_i && instr_ready_o && instr_word_i[15:13] == 3'b101;
   // Skip condition of the held word
   wire hit = (w[15:12] == 4'hb) ? !rd_data_i[w[11:9]] : rd_data_i[w[11:9]];
   wire low = w[7:0] <= 8'h5f; // Low access bank part
   // Holds the word for the execute cycle
   always @(posedge sys_clk_i)
      if (take)
         w <= instr_word_i;
   sequence s_skip; rd_en_o && hit; endsequence
   sequence s_nop2; no_operation_o [*2] ##1 done_o; endsequence
   AST_TAKE: assert property (take |=> rd_en_o && !instr_ready_o) else $error("no execute");
   AST_CLR: assert property (rd_en_o && w[15:12] == 4'hb && !rd_data_i[w[11:9]] |=> skip_o) else $error("clr");
   AST_SET: assert property (rd_en_o && w[15:12] == 4'ha && rd_data_i[w[11:9]] |=> skip_o) else $error("set");
   AST_NOSK: assert property (rd_en_o && !hit |=> done_o && !skip_o) else $error("no skip");
   AST_DISC: assert property (skip_o |-> discard_o && no_operation_o) else $error("discard");
   AST_ONE: assert property (s_skip ##0 !next_two_word_i |=> ##1 done_o && !no_operation_o) else $error("two");
   AST_TWO: assert property (s_skip ##0 next_two_word_i |=> s_nop2) else $error("three");
   AST_BSR: assert property (rd_en_o && w[8] |-> rd_addr_o == {bank_select_register_i, w[7:0]}) else $error("bsr");
   AST_ACC: assert property (rd_en_o && !w[8] && !(ext_instr_en_i && low) |-> !indexed_o && rd_addr_o ==
      {low ? 4'h0 : 4'hf, w[7:0]}) else $error("access");
   AST_IDX: assert property (rd_en_o && !w[8] && ext_instr_en_i && low |-> indexed_o && rd_addr_o ==
      index_base_i + w[7:0]) else $error("indexed");
endmodule // bts_mon
bind bts_bit_test_skip bts_mon i_mon(.*);
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the bit test skip block.
// Assumes: Inputs change at the falling edge.
// Notes: ce_i drops only in the freeze scenario.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic sys_clk_i = 0, srst_i = 1, ce_i = 1, instr_valid_i = 0, next_two_word_i = 0, ext_instr_en_i = 0;
   logic [15:0] instr_word_i = 0;
   logic [3:0] bank_select_register_i = 4'h5;
   logic [11:0] index_base_i = 12'h100;
   logic [7:0] rd_data_i = 0;
   wire instr_ready_o, rd_en_o, indexed_o, skip_o, discard_o, no_operation_o, done_o;
   wire [11:0] rd_addr_o;
   int n_mismatch = 0, cmp_count = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   bts_bit_test_skip i_bts_bit_test_skip (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i),
      .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .instr_ready_o(instr_ready_o),
      .next_two_word_i(next_two_word_i), .ext_instr_en_i(ext_instr_en_i), .index_base_i(index_base_i),
      .bank_select_register_i(bank_select_register_i), .rd_addr_o(rd_addr_o), .rd_en_o(rd_en_o),
      .indexed_o(indexed_o), .rd_data_i(rd_data_i), .skip_o(skip_o), .discard_o(discard_o),
      .no_operation_o(no_operation_o), .done_o(done_o));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One instruction; n counts its cycles
   task exec(input logic [15:0] w, input logic [7:0] d, input logic two, es, input logic [2:0] en,
      input logic [11:0] ea, input logic ei);
      logic sk, dc, ix;
      logic [11:0] a;
      int n, no_operation;
      instr_word_i = w;
      rd_data_i = d;
      next_two_word_i = two;
      instr_valid_i = 1;
      @(negedge sys_clk_i);
      // Execute cycle: counting starts here
      instr_valid_i = 0;
      sk = 0;
      dc = 0;
      n = 0;
      no_operation = 0;
      a = rd_addr_o;
      ix = indexed_o;
      chk({rd_en_o, instr_ready_o}, 2'b10);
      while (done_o !== 1'b1 && n < 8)
      begin
         sk |= skip_o;
         dc |= discard_o;
         no_operation += no_operation_o;
         @(negedge sys_clk_i);
         n++;
      end
      if (n == 8)
      begin
         n_mismatch++;
         wrap_up;
      end
      else
      begin
         chk(n, en);
         chk(sk, es);
         chk(dc, es);
         chk(no_operation, en - 3'd1);
         chk(a, ea);
         chk(ix, ei);
      end
   endtask
   task t_clear;
      exec({4'hb, 3'd3, 1'b1, 8'h23}, 8'hf7, 0, 1, 2, 12'h523, 0);
      exec({4'hb, 3'd3, 1'b1, 8'h23}, 8'h08, 0, 0, 1, 12'h523, 0);
      $display("t_clear end");
   endtask
   task t_set;
      exec({4'ha, 3'd7, 1'b1, 8'h10}, 8'h80, 1, 1, 3, 12'h510, 0);
      exec({4'ha, 3'd7, 1'b1, 8'h10}, 8'h7f, 1, 0, 1, 12'h510, 0);
      $display("t_set end");
   endtask
   task t_access;
      exec({4'hb, 3'd0, 1'b0, 8'h5f}, 8'h01, 0, 0, 1, 12'h05f, 0);
      exec({4'hb, 3'd0, 1'b0, 8'h60}, 8'h01, 0, 0, 1, 12'hf60, 0);
      ext_instr_en_i = 1;
      exec({4'ha, 3'd0, 1'b0, 8'h5f}, 8'h01, 0, 1, 2, 12'h15f, 1);
      exec({4'ha, 3'd0, 1'b0, 8'h60}, 8'h01, 0, 1, 2, 12'hf60, 0);
      $display("t_access end");
   endtask
   task t_ignore;
      instr_word_i = 16'h9000;
      instr_valid_i = 1;
      repeat (3) @(negedge sys_clk_i) chk({rd_en_o, instr_ready_o}, 2'b01);
      instr_valid_i = 0;
      $display("t_ignore end");
   endtask
   // Enable low blocks a take, then holds a taken word in execute
   task t_freeze;
      @(negedge sys_clk_i);
      ce_i = 0;
      instr_word_i = {4'hb, 3'd1, 1'b1, 8'h40};
      rd_data_i = 8'h00;
      next_two_word_i = 0;
      instr_valid_i = 1;
      repeat (2) @(negedge sys_clk_i) chk(rd_en_o, 0);
      ce_i = 1;
      @(negedge sys_clk_i);
      ce_i = 0;
      instr_valid_i = 0;
      repeat (2) @(negedge sys_clk_i) chk({rd_en_o, skip_o, instr_ready_o}, 3'b100);
      ce_i = 1;
      @(negedge sys_clk_i);
      chk({skip_o, discard_o, no_operation_o}, 3'b111);
      @(negedge sys_clk_i);
      chk(done_o, 1);
      $display("t_freeze end");
   endtask
   initial
   begin
      repeat (3) @(negedge sys_clk_i);
      srst_i = 0;
      t_clear;
      t_set;
      t_access;
      t_ignore;
      t_freeze;
      wrap_up;
   end
endmodule // tb_top
`default_nettype wire
